// [verilog/emmc_defs.svh]
// constants for the external memory bus mode controller
`ifndef EMMC_DEFS_SVH
`define EMMC_DEFS_SVH
`define EMMC_CFG_ADDR 12'h000
`define EMMC_REQ_ADDR 12'h004
`define EMMC_STAT_ADDR 12'h008
`define EMMC_CFG_RESET 8'h03
`define EMMC_MUX_BIT 4
`define EMMC_MODE_HI 3
`define EMMC_MODE_LO 2
`define EMMC_ALE_HI 1
`define EMMC_ALE_LO 0
`define EMMC_CFG_MASK 8'h1F
`define EMMC_ONCHIP_LIMIT 16'h2000
`define EMMC_ONCHIP_MASK 16'h1FFF
`define EMMC_REQ_WRITE_BIT 24
`define EMMC_REQ_GO_BIT 25
// strobe outlasts the two synchroniser flops so read data is sampled live
`define EMMC_STROBE_CYCLES 3'h3
`define EMMC_STAT_BUSY_BIT 8
`define EMMC_STAT_OFFCHIP_BIT 9
`define EMMC_STAT_ONCHIP_BIT 10
`endif

// [verilog/emmc_pkg.sv]
// types for the external memory bus mode controller
package emmc_pkg;
  typedef enum logic [1:0] {
    EMMC_ONCHIP_ONLY,
    EMMC_SPLIT_NOBANK,
    EMMC_SPLIT_BANK,
    EMMC_OFFCHIP_ONLY
  } emmc_mode_type;
  typedef enum {
    EMMC_IDLE,
    EMMC_ALE_HIGH,
    EMMC_ALE_LOW,
    EMMC_STROBE,
    EMMC_DONE
  } emmc_state_type;
endpackage

// [verilog/emmc_sync_if.sv]
// carrier between the top and its pin synchroniser
`timescale 1ns/1ps
`default_nettype none
interface emmc_sync_if;
  logic [7:0] data_sync;
  modport src (output data_sync);
  modport dst (input data_sync);
endinterface
`default_nettype wire

// [verilog/emmc_sync.sv]
// two-stage synchroniser for the external data pins
`timescale 1ns/1ps
`default_nettype none
module emmc_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pins_in,
  emmc_sync_if.src sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;
  if (WIDTH != 8) begin : g_width_bad
    $error("emmc_sync supports 8 bits only");
  end
  always_comb begin
    next_stage1 = pins_in;
    next_stage2 = stage1;
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end
  assign sync.data_sync = stage2;
endmodule
`default_nettype wire

// [verilog/emmc_top.sv]
// external memory bus mode controller with APB configuration port
//
// Overview of operation
// - config bit 4 chooses multiplexed or non-multiplexed bus operation.
// - bit 4 set: address and data on separate dedicated pins.
// - bit 4 clear: low address byte and data share the pins.
// - bits 3-2 pick on-chip only, split, split with bank, off-chip.
// - split modes send addresses below 8k on-chip, others external.
// - multiplexed mode puts data and low address on eight shared pins.
// - this block drives the address-latch strobe in multiplexed mode.
// - first phase: strobe high, low address byte on shared pins.
// - strobe falls high to low; the second phase starts after its low time.
// - second phase: data on shared pins while read/write strobe active.
// - bits 1-0 set strobe high and low time, 1 to 4 clocks.
// - drivers off on every pin acting as input during an access.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "emmc_defs.svh"
module emmc_top import emmc_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] addr_out,
  output logic [15:0] addr_oe,
  output logic [7:0] data_out,
  output logic [7:0] data_oe,
  input wire logic [7:0] data_in,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic onchip_req,
  output logic [12:0] onchip_addr
);
  if (ADDR_W < 4) begin : g_addr_w_bad
    $error("emmc_top needs at least 4 address bits");
  end

  emmc_sync_if sync_bus ();
  emmc_sync #(.WIDTH(8)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pins_in(data_in),
    .sync(sync_bus)
  );

  function automatic logic [2:0] ale_cycles(input logic [1:0] sel);
    ale_cycles = {1'b0, sel} + 3'h1;
  endfunction

  function automatic logic is_offchip(input emmc_mode_type m,
                                      input logic [15:0] a);
    unique case (m)
      EMMC_ONCHIP_ONLY: is_offchip = 1'b0;
      EMMC_SPLIT_NOBANK,
      EMMC_SPLIT_BANK: is_offchip = (a >= `EMMC_ONCHIP_LIMIT);
      EMMC_OFFCHIP_ONLY: is_offchip = 1'b1;
    endcase
  endfunction

  logic [7:0] config_reg;
  logic [15:0] req_addr;
  logic [7:0] req_wdata;
  logic req_write;
  logic [7:0] rd_data;
  emmc_state_type state;
  logic [2:0] count;
  logic [7:0] next_config_reg;
  logic [15:0] next_req_addr;
  logic [7:0] next_req_wdata;
  logic next_req_write;
  logic [7:0] next_rd_data;
  emmc_state_type next_state;
  logic [2:0] next_count;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [15:0] next_addr_out;
  logic [15:0] next_addr_oe;
  logic [7:0] next_data_out;
  logic [7:0] next_data_oe;
  logic next_ale;
  logic next_rd_n;
  logic next_wr_n;
  logic next_onchip_req;
  logic [12:0] next_onchip_addr;
  logic setup_phase;
  logic non_mux;
  emmc_mode_type mem_mode;
  logic [2:0] ale_len;
  logic go;
  logic access_done;

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign non_mux = config_reg[`EMMC_MUX_BIT];
  assign mem_mode = emmc_mode_type'(config_reg[`EMMC_MODE_HI:`EMMC_MODE_LO]);
  assign ale_len = ale_cycles(config_reg[`EMMC_ALE_HI:`EMMC_ALE_LO]);
  // taken at the access edge; a setup refused as busy never starts one
  assign go = access_done && pwrite && paddr == `EMMC_REQ_ADDR
              && pwdata[`EMMC_REQ_GO_BIT] && !pslverr && state == EMMC_IDLE;

  // apb: no wait states, answer registered in the setup cycle;
  // writes land only at the edge that completes the access
  always_comb begin
    next_config_reg = config_reg;
    next_prdata = 32'h0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (access_done && pwrite && paddr == `EMMC_CFG_ADDR) begin
      next_config_reg = pwdata[7:0] & `EMMC_CFG_MASK;
    end
    if (setup_phase) begin
      next_pready = 1'b1;
      unique case (paddr)
        `EMMC_CFG_ADDR: begin
          next_prdata = {24'h0, config_reg};
        end
        `EMMC_REQ_ADDR: begin
          if (pwrite && state != EMMC_IDLE) begin
            next_pslverr = 1'b1;
          end
          next_prdata = {6'h0, 1'b0, req_write, req_addr, req_wdata};
        end
        `EMMC_STAT_ADDR: begin
          next_pslverr = pwrite;
          next_prdata = {21'h0, onchip_req, !rd_n || !wr_n,
                         state != EMMC_IDLE, rd_data};
        end
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // access sequencer
  always_comb begin
    next_state = state;
    next_count = count;
    next_req_addr = req_addr;
    next_req_wdata = req_wdata;
    next_req_write = req_write;
    next_rd_data = rd_data;
    next_addr_out = addr_out;
    next_addr_oe = 16'h0;
    next_data_out = data_out;
    next_data_oe = 8'h0;
    next_ale = 1'b0;
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    next_onchip_req = 1'b0;
    next_onchip_addr = onchip_addr;
    unique case (state)
      EMMC_IDLE: begin
        if (go) begin
          next_req_addr = pwdata[23:8];
          next_req_wdata = pwdata[7:0];
          next_req_write = pwdata[`EMMC_REQ_WRITE_BIT];
          if (!is_offchip(mem_mode, pwdata[23:8])) begin
            // on-chip: addresses alias inside the 8k space
            next_onchip_req = 1'b1;
            next_onchip_addr = pwdata[20:8] & 13'(`EMMC_ONCHIP_MASK);
          end else if (non_mux) begin
            next_state = EMMC_STROBE;
            next_count = `EMMC_STROBE_CYCLES;
            next_addr_out = pwdata[23:8];
            next_addr_oe = 16'hFFFF;
            next_data_out = pwdata[7:0];
            next_data_oe = {8{pwdata[`EMMC_REQ_WRITE_BIT]}};
            next_rd_n = pwdata[`EMMC_REQ_WRITE_BIT];
            next_wr_n = !pwdata[`EMMC_REQ_WRITE_BIT];
          end else begin
            next_state = EMMC_ALE_HIGH;
            next_count = ale_len;
            next_ale = 1'b1;
            next_addr_out = {pwdata[23:16], 8'h00};
            next_addr_oe = 16'hFF00;
            next_data_out = pwdata[15:8];
            next_data_oe = 8'hFF;
          end
        end
      end
      EMMC_ALE_HIGH: begin
        next_addr_oe = 16'hFF00;
        next_data_oe = 8'hFF;
        next_ale = 1'b1;
        next_count = count - 3'h1;
        if (count == 3'h1) begin
          next_ale = 1'b0;
          next_state = EMMC_ALE_LOW;
          next_count = ale_len;
        end
      end
      EMMC_ALE_LOW: begin
        // address held on the pins while the latch closes
        next_addr_oe = 16'hFF00;
        next_data_oe = 8'hFF;
        next_count = count - 3'h1;
        if (count == 3'h1) begin
          next_state = EMMC_STROBE;
          next_count = `EMMC_STROBE_CYCLES;
          next_data_out = req_wdata;
          next_data_oe = {8{req_write}};
          next_rd_n = req_write;
          next_wr_n = !req_write;
        end
      end
      EMMC_STROBE: begin
        next_addr_oe = non_mux ? 16'hFFFF : 16'hFF00;
        next_data_oe = {8{req_write}};
        next_rd_n = req_write;
        next_wr_n = !req_write;
        next_count = count - 3'h1;
        if (count == 3'h1) begin
          next_rd_n = 1'b1;
          next_wr_n = 1'b1;
          next_state = EMMC_DONE;
          if (!req_write) begin
            next_rd_data = sync_bus.data_sync;
          end
        end
      end
      EMMC_DONE: begin
        // one hold cycle: strobes off, address and write data still driven; all drivers off from the next cycle
        next_state = EMMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      config_reg <= `EMMC_CFG_RESET;
      state <= EMMC_IDLE;
      count <= 3'h0;
      req_addr <= 16'h0;
      req_wdata <= 8'h0;
      req_write <= 1'b0;
      rd_data <= 8'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      addr_out <= 16'h0;
      addr_oe <= 16'h0;
      data_out <= 8'h0;
      data_oe <= 8'h0;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      onchip_req <= 1'b0;
      onchip_addr <= 13'h0;
    end else begin
      config_reg <= next_config_reg;
      state <= next_state;
      count <= next_count;
      req_addr <= next_req_addr;
      req_wdata <= next_req_wdata;
      req_write <= next_req_write;
      rd_data <= next_rd_data;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      addr_out <= next_addr_out;
      addr_oe <= next_addr_oe;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      ale <= next_ale;
      rd_n <= next_rd_n;
      wr_n <= next_wr_n;
      onchip_req <= next_onchip_req;
      onchip_addr <= next_onchip_addr;
    end
  end
endmodule
`default_nettype wire

// [tb/emmc_sram.sv]
// far side model: external sram behind a transparent address latch
`timescale 1ns/1ps
`default_nettype none
module emmc_sram (
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic nonmux,
  input wire logic [15:0] addr_out,
  input wire logic [15:0] addr_oe,
  input wire logic [7:0] bus,
  input wire logic [7:0] data_oe,
  output logic [7:0] data_in
);
  logic [7:0] lat;
  logic [7:0] q;
  logic [7:0] mem [0:65535];
  logic [15:0] a;
  logic drv;
  assign a = nonmux ? addr_out : {addr_out[15:8], lat};
  // chip enabled by the address, outputs only while the pins are released
  assign drv = addr_oe[15] === 1'b1 && data_oe === 8'h00;
  always_latch if (ale) lat <= bus;
  always @* if (wr_n === 1'b0) mem[a] = bus;
  always @* if (drv) q = mem[a];
  // released bus shows the inverse, so a stale value never passes
  assign data_in = drv ? q : ~q;
endmodule
`default_nettype wire

// [tb/emmc_top_sva.sv]
// assertions on the memory controller top ports
`timescale 1ns/1ps
`default_nettype none
module emmc_top_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic onchip_req,
  input wire logic [15:0] addr_oe,
  input wire logic [7:0] data_oe
);
  logic [3:0] n_hi;
  logic [3:0] next_n_hi;
  always_comb next_n_hi = ale ? n_hi + 4'h1 : 4'h0;
  always_ff @(posedge clk_sys) n_hi <= nrst ? next_n_hi : 4'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  rdy_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ale_width_a: assert property (n_hi <= 4'h4)
    else $error("latch strobe too long");
  ale_addr_phase_a: assert property (ale |-> data_oe == 8'hFF
    && addr_oe == 16'hFF00) else $error("address phase pins wrong");
  strobe_after_fall_a: assert property ($fell(ale) |-> rd_n && wr_n)
    else $error("strobe during latch fall");
  ale_to_strobe_a: assert property ($fell(ale) |->
    ##[1:4] !(rd_n && wr_n)) else $error("no strobe after latch phase");
  read_release_a: assert property (!rd_n |-> data_oe == 8'h00)
    else $error("data driven during read");
  write_drive_a: assert property (!wr_n |->
    data_oe == 8'hFF && !ale) else $error("data not driven during write");
  onchip_quiet_a: assert property (onchip_req |->
    rd_n && wr_n && !ale) else $error("pins moved on on-chip access");
  reset_idle_a: assert property (@(posedge clk_sys)
    disable iff (1'b0) !nrst |=> !ale && rd_n && wr_n && data_oe == 8'h00)
    else $error("pins not idle after reset");
  cover property ($fell(ale));
  cover property (!wr_n);
  cover property (!rd_n);
  cover property (onchip_req);
endmodule
bind emmc_top emmc_top_sva u_sva (.clk_sys, .nrst, .psel, .penable, .pready,
  .ale, .rd_n, .wr_n, .onchip_req, .addr_oe, .data_oe);
`default_nettype wire

// [tb/emmc_bench.sv]
// self-checking bench for the memory controller top
`timescale 1ns/1ps
`default_nettype none
`include "emmc_defs.svh"
module emmc_bench;
  logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, nonmux = 1'b0, pready, pslverr, err, ale, rd_n, wr_n;
  logic onchip_req, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] addr_out, addr_oe, st_a;
  logic [7:0] data_out, data_oe, data_in, bus;
  logic [12:0] onchip_addr, on_a;
  logic [1:0] md [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [15:0] ad [6] = '{16'h4005, 16'h1FFF, 16'h2000, 16'h1FFF,
    16'h2000, 16'h0010};
  int n_fail = 0, n_checks = 0, n_ale = 0, n_on = 0, n_str = 0;
  int b_ale, b_on, b_str;
  always #20 clk_sys = ~clk_sys;
  assign bus = (data_out & data_oe) | (data_in & ~data_oe);
  emmc_top #(.ADDR_W(12)) dut (.clk_sys, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .addr_out, .addr_oe,
    .data_out, .data_oe, .data_in, .ale, .rd_n, .wr_n, .onchip_req,
    .onchip_addr);
  emmc_sram sram (.ale, .rd_n, .wr_n, .nonmux, .addr_out, .addr_oe, .bus,
    .data_oe, .data_in);
  // values sampled before the edge's own updates land
  always @(posedge clk_sys) begin
    if (ale === 1'b1) n_ale++;
    if (onchip_req === 1'b1) begin
      n_on++;
      on_a = onchip_addr;
    end
    if ((rd_n & wr_n) === 1'b0) begin
      n_str++;
      st_a = addr_out;
    end
  end
  task automatic wrap_up;
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 9 && pready !== 1'b1; i++) @(posedge clk_sys);
    if (i == 9) begin
      n_fail++;
      wrap_up;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one request, then poll status until busy clears
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    int i;
    b_ale = n_ale;
    b_on = n_on;
    b_str = n_str;
    apb(1'b1, `EMMC_REQ_ADDR, {6'h0, 1'b1, w, a, d});
    for (i = 0; i < 30; i++) begin
      apb(1'b0, `EMMC_STAT_ADDR, 32'h0);
      if (rd[8] === 1'b0) break;
    end
    if (i == 30) begin
      n_fail++;
      wrap_up;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(1'b0, `EMMC_CFG_ADDR, 32'h0);
    chk("cfg", 32'h03, rd);
    apb(1'b1, `EMMC_CFG_ADDR, 32'hFF);
    apb(1'b0, `EMMC_CFG_ADDR, 32'h0);
    chk("cfg", 32'h1F, rd);
    apb(1'b0, 12'h00C, 32'h0);
    chk("err", 32'h1, err);
    for (int w = 0; w < 4; w++) begin
      apb(1'b1, `EMMC_CFG_ADDR, 32'h0C + w);
      acc(1'b1, 16'h2100 + w, 8'hA0 + w);
      chk("ale", w + 1, n_ale - b_ale);
      chk("adr", 16'h2100 + w, {st_a[15:8], sram.lat});
      acc(1'b0, 16'h2100 + w, 8'h00);
      chk("dat", 8'hA0 + w, rd[7:0]);
    end
    nonmux <= 1'b1;
    apb(1'b1, `EMMC_CFG_ADDR, 32'h1C);
    acc(1'b1, 16'h3344, 8'h5A);
    chk("ale", 32'h0, n_ale - b_ale);
    chk("adr", 16'h3344, st_a);
    acc(1'b0, 16'h3344, 8'h00);
    chk("dat", 8'h5A, rd[7:0]);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, `EMMC_CFG_ADDR, {27'h0, 1'b1, md[k], 2'b00});
      acc(1'b0, ad[k], 8'h00);
      e = md[k] == 2'h0 || (md[k] != 2'h3 && ad[k] < 16'h2000);
      chk("on", e, n_on - b_on);
      chk("ext", e ? 32'h0 : `EMMC_STROBE_CYCLES, n_str - b_str);
      if (e) chk("oa", ad[k] & 16'h1FFF, on_a);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
